// ### design/fmc_pkg.sv
`default_nettype none
package fmc_pkg;
    // clock rate and counter width
    localparam int unsigned CYC_PER_US     = 100;
    localparam int unsigned CNT_W          = 32;
    // clear-to-send delays, full duplex by code, half duplex single
    localparam int unsigned CTS_FD0_MS     = 402;
    localparam int unsigned CTS_FD1_MS     = 30;
    localparam int unsigned CTS_FD2_MS     = 350;
    localparam int unsigned CTS_HD_MS      = 201;
    // delayed carrier detect on and off delays
    localparam int unsigned CD_ON_FD0_MS   = 301;
    localparam int unsigned CD_ON_FD1_MS   = 4;
    localparam int unsigned CD_ON_FD2_MS   = 152;
    localparam int unsigned CD_OFF_FD0_MS  = 21;
    localparam int unsigned CD_OFF_FD1_MS  = 21;
    localparam int unsigned CD_OFF_FD2_MS  = 4;
    localparam int unsigned CD_ON_HD_US    = 7500;
    localparam int unsigned CD_OFF_HD_US   = 5200;
    // squelch hold, soft turn-off and bit period
    localparam int unsigned SQUELCH_MS     = 150;
    localparam int unsigned SOFT_TURNOFF_US = 5000;
    localparam int unsigned BIT_RATE_BPS   = 300;
    localparam int unsigned AMP_STEPS      = 16;
    // derived cycle counts
    localparam int unsigned CTS_FD0_CYC    = CTS_FD0_MS * 1000 * CYC_PER_US;
    localparam int unsigned CTS_FD1_CYC    = CTS_FD1_MS * 1000 * CYC_PER_US;
    localparam int unsigned CTS_FD2_CYC    = CTS_FD2_MS * 1000 * CYC_PER_US;
    localparam int unsigned CTS_HD_CYC     = CTS_HD_MS * 1000 * CYC_PER_US;
    localparam int unsigned CD_ON_FD0_CYC  = CD_ON_FD0_MS * 1000 * CYC_PER_US;
    localparam int unsigned CD_ON_FD1_CYC  = CD_ON_FD1_MS * 1000 * CYC_PER_US;
    localparam int unsigned CD_ON_FD2_CYC  = CD_ON_FD2_MS * 1000 * CYC_PER_US;
    localparam int unsigned CD_OFF_FD0_CYC = CD_OFF_FD0_MS * 1000 * CYC_PER_US;
    localparam int unsigned CD_OFF_FD1_CYC = CD_OFF_FD1_MS * 1000 * CYC_PER_US;
    localparam int unsigned CD_OFF_FD2_CYC = CD_OFF_FD2_MS * 1000 * CYC_PER_US;
    localparam int unsigned CD_ON_HD_CYC   = CD_ON_HD_US * CYC_PER_US;
    localparam int unsigned CD_OFF_HD_CYC  = CD_OFF_HD_US * CYC_PER_US;
    localparam int unsigned SQUELCH_CYC    = SQUELCH_MS * 1000 * CYC_PER_US;
    localparam int unsigned SOFT_CYC       = SOFT_TURNOFF_US * CYC_PER_US;
    localparam int unsigned BIT_CYC        = 1000000 * CYC_PER_US / BIT_RATE_BPS;
    // amplitude levels and reset values
    localparam logic [3:0]  AMP_FULL       = 4'hf;
    localparam logic [3:0]  AMP_ZERO       = 4'h0;
    localparam int unsigned FIFO_DEPTH     = 8;
    localparam int unsigned FIFO_W         = 1;
    localparam logic        RD_STOP_LEVEL  = 1'h1;
endpackage
`default_nettype wire

// ### design/fmc_timer_if.sv
`default_nettype none
interface fmc_timer_if;
    logic        start;
    logic [31:0] load;
    logic        busy;
    logic        done;
    modport owner (output start, output load, input busy, input done);
    modport timer (input start, input load, output busy, output done);
endinterface
`default_nettype wire

// ### design/fmc_delay_timer.sv
`default_nettype none
module fmc_delay_timer (
    // clock and reset
    input  wire logic   core_clk,
    input  wire logic   arst_n,
    // control from owner
    fmc_timer_if.timer  tif
);
    logic [31:0] cnt_ff;
    logic        busy_ff;

    // restartable down counter, reloads on every start
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_ff  <= 32'h0;
            busy_ff <= 1'b0;
        end else if (tif.start) begin
            cnt_ff  <= tif.load;
            busy_ff <= 1'b1;
        end else if (busy_ff) begin
            cnt_ff  <= cnt_ff - 32'h1;
            busy_ff <= (cnt_ff != 32'h1);
        end
    end

    // done pulses in the last counted cycle
    assign tif.busy = busy_ff;
    assign tif.done = busy_ff && (cnt_ff == 32'h1) && !tif.start;

    a_timer_reload: assert property (@(posedge core_clk) disable iff (!arst_n)
        tif.start |=> busy_ff && cnt_ff == $past(tif.load))
        else $error("timer did not reload on start");
endmodule
`default_nettype wire

// ### design/fmc_fifo.sv
`default_nettype none
module fmc_fifo #(
    parameter int unsigned W     = 1,
    parameter int unsigned DEPTH = 8
) (
    // clock and reset
    input  wire logic          core_clk,
    input  wire logic          arst_n,
    // fill side
    input  wire logic          in_valid,
    output logic               in_ready,
    input  wire logic [W-1:0]  in_data,
    // drain side
    output logic               out_valid,
    input  wire logic          out_ready,
    output logic [W-1:0]       out_data
);
    localparam int unsigned PW = $clog2(DEPTH);
    localparam int unsigned CW = $clog2(DEPTH + 1);

    logic [W-1:0]  mem [DEPTH];
    logic [PW-1:0] wr_ff;
    logic [PW-1:0] rd_ff;
    logic [CW-1:0] count_ff;
    logic          push;
    logic          pop;

    // full and empty from the word count
    assign in_ready  = (count_ff != CW'(DEPTH));
    assign out_valid = (count_ff != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem[rd_ff];

    // storage write
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wr_ff] <= in_data;
        end
    end

    // pointers and count
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_ff    <= '0;
            rd_ff    <= '0;
            count_ff <= '0;
        end else begin
            if (push) begin
                wr_ff <= (wr_ff == PW'(DEPTH - 1)) ? '0 : wr_ff + PW'(1);
            end
            if (pop) begin
                rd_ff <= (rd_ff == PW'(DEPTH - 1)) ? '0 : rd_ff + PW'(1);
            end
            count_ff <= count_ff + CW'(push) - CW'(pop);
        end
    end

    a_fifo_no_overflow: assert property (@(posedge core_clk) disable iff (!arst_n)
        count_ff == CW'(DEPTH) && !pop |=> count_ff == CW'(DEPTH))
        else $error("fifo count moved while full");
endmodule
`default_nettype wire

// ### design/fmc_modem_ctrl.sv
// How it works
// - while transmit request is low, modulate the carrier from the transmit bit
// - after request rises, keep modulating while amplitude ramps down over soft turn-off
// - raw carrier detect follows the detector comparator with no logic delay
// - delayed carrier detect comes from raw detect through clock-timed counters
// - while delayed carrier detect is high, receive data is held high
// - demodulation stops when raw carrier detect goes inactive
// - between demod stop and delayed detect high, receive data sits at fixed level
// - half-duplex variant has squelch timer, enabled by two-wire select low
// - two-wire half duplex, request low: receive data and delayed detect held high
// - after request rises in two-wire mode, hold both high for squelch time
// - clear-to-send asserts a delay after request falls, code-selected in full duplex, fixed in half duplex, drops at once
// - timer selects choose full-duplex detect on/off delays; code 11, or single select high in half duplex, hands timing outside
// - one shared pin is answer/originate or two-wire select; timer pins shared too
`default_nettype none
module fmc_modem_ctrl #(
    parameter int unsigned P_CTS_FD0_CYC    = fmc_pkg::CTS_FD0_CYC,
    parameter int unsigned P_CTS_FD1_CYC    = fmc_pkg::CTS_FD1_CYC,
    parameter int unsigned P_CTS_FD2_CYC    = fmc_pkg::CTS_FD2_CYC,
    parameter int unsigned P_CTS_HD_CYC     = fmc_pkg::CTS_HD_CYC,
    parameter int unsigned P_CD_ON_FD0_CYC  = fmc_pkg::CD_ON_FD0_CYC,
    parameter int unsigned P_CD_ON_FD1_CYC  = fmc_pkg::CD_ON_FD1_CYC,
    parameter int unsigned P_CD_ON_FD2_CYC  = fmc_pkg::CD_ON_FD2_CYC,
    parameter int unsigned P_CD_OFF_FD0_CYC = fmc_pkg::CD_OFF_FD0_CYC,
    parameter int unsigned P_CD_OFF_FD1_CYC = fmc_pkg::CD_OFF_FD1_CYC,
    parameter int unsigned P_CD_OFF_FD2_CYC = fmc_pkg::CD_OFF_FD2_CYC,
    parameter int unsigned P_CD_ON_HD_CYC   = fmc_pkg::CD_ON_HD_CYC,
    parameter int unsigned P_CD_OFF_HD_CYC  = fmc_pkg::CD_OFF_HD_CYC,
    parameter int unsigned P_SQUELCH_CYC    = fmc_pkg::SQUELCH_CYC,
    parameter int unsigned P_SOFT_CYC       = fmc_pkg::SOFT_CYC,
    parameter int unsigned P_BIT_CYC        = fmc_pkg::BIT_CYC,
    parameter logic        P_RD_STOP_LEVEL  = fmc_pkg::RD_STOP_LEVEL
) (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        arst_n,
    // terminal transmit side
    input  wire logic        transmit_request_n,
    input  wire logic        transmit_bit_in,
    input  wire logic        transmit_valid,
    output logic             transmit_ready,
    // configuration pins
    input  wire logic        half_duplex_variant,
    input  wire logic        mode_select_pin,
    input  wire logic        timer_select_lo,
    input  wire logic        timer_select_hi,
    // analog front end and external timers
    input  wire logic        detector_comparator_n,
    input  wire logic        demod_bit,
    input  wire logic        external_cts_n,
    input  wire logic        external_cd_n,
    // modulator control
    output logic             modulated_out,
    output logic [3:0]       tx_amplitude,
    output logic             tx_enable,
    output logic             answer_mode,
    output logic             answer_tone_on,
    // terminal receive side
    output logic             raw_carrier_detect_n,
    output logic             delayed_carrier_detect_n,
    output logic             receive_data,
    output logic             clear_to_send_n,
    output logic             demod_enable
);
    localparam int unsigned SOFT_STEP_CYC =
        (P_SOFT_CYC / fmc_pkg::AMP_STEPS > 0) ? P_SOFT_CYC / fmc_pkg::AMP_STEPS : 1;

    // picks one of three loads by a two-bit timer code
    function automatic logic [31:0] pick3(input logic [1:0] code,
                                          input int unsigned a,
                                          input int unsigned b,
                                          input int unsigned c);
        logic [31:0] r;
        r = 32'(a);
        if (code == 2'b01) begin
            r = 32'(b);
        end else if (code == 2'b10) begin
            r = 32'(c);
        end
        return r;
    endfunction

    fmc_timer_if cts_if ();
    fmc_timer_if cd_if ();
    fmc_timer_if sq_if ();
    fmc_timer_if soft_if ();

    logic        two_wire_select_n;
    logic        timer_select_single;
    logic        answer_tone_enable;
    logic [1:0]  tcode;
    logic        ext_timing;
    logic        sq_enable;
    logic        req_d_ff;
    logic        raw_d_ff;
    logic        req_fall;
    logic        req_rise;
    logic        raw_fall;
    logic        raw_rise;
    logic        squelch;
    logic        cd2_core_ff;
    logic        cd2_ff;
    logic        rd_ff;
    logic        cts_n_ff;
    logic        nxt_cd2;
    logic        nxt_rd;
    logic        tx_active;
    logic        tx_enable_ff;
    logic        mod_bit_ff;
    logic [3:0]  amp_ff;
    logic [31:0] step_cnt_ff;
    logic [31:0] bit_cnt_ff;
    logic        bit_tick;
    logic        fifo_valid;
    logic        fifo_pop;
    logic        fifo_bit;
    logic        answer_mode_ff;
    logic        tone_on_ff;

    // shared pin roles by variant
    assign two_wire_select_n   = half_duplex_variant ? mode_select_pin : 1'b1;
    assign timer_select_single = timer_select_lo;
    assign answer_tone_enable  = half_duplex_variant & timer_select_hi;
    assign tcode      = half_duplex_variant ? {1'b0, timer_select_single}
                                            : {timer_select_hi, timer_select_lo};
    assign ext_timing = half_duplex_variant ? timer_select_single
                                            : (timer_select_hi & timer_select_lo);

    // edge detect on request and raw detect
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            req_d_ff <= 1'b1;
            raw_d_ff <= 1'b1;
        end else begin
            req_d_ff <= transmit_request_n;
            raw_d_ff <= detector_comparator_n;
        end
    end

    assign req_fall = !transmit_request_n && req_d_ff;
    assign req_rise = transmit_request_n && !req_d_ff;
    assign raw_fall = !detector_comparator_n && raw_d_ff;
    assign raw_rise = detector_comparator_n && !raw_d_ff;

    // raw detect passes straight through; demodulator runs only with carrier
    assign raw_carrier_detect_n = detector_comparator_n;
    assign demod_enable         = !detector_comparator_n;

    // clear-to-send delay timer, restarted by every request fall unless timing is external
    assign cts_if.start = req_fall && !ext_timing;
    assign cts_if.load  = half_duplex_variant ? 32'(P_CTS_HD_CYC)
                        : pick3(tcode, P_CTS_FD0_CYC, P_CTS_FD1_CYC, P_CTS_FD2_CYC);

    fmc_delay_timer u_cts_tmr (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .tif      (cts_if.timer)
    );

    // clear-to-send output, drops the cycle after request rises
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cts_n_ff <= 1'b1;
        end else if (transmit_request_n) begin
            cts_n_ff <= 1'b1;
        end else if (ext_timing) begin
            cts_n_ff <= external_cts_n;
        end else if (cts_if.done) begin
            cts_n_ff <= 1'b0;
        end
    end

    // detect on/off timer, restarted on each raw edge with the matching delay unless timing is external
    assign cd_if.start = (raw_fall || raw_rise) && !ext_timing;
    assign cd_if.load  = half_duplex_variant
        ? (raw_fall ? 32'(P_CD_ON_HD_CYC) : 32'(P_CD_OFF_HD_CYC))
        : (raw_fall ? pick3(tcode, P_CD_ON_FD0_CYC, P_CD_ON_FD1_CYC, P_CD_ON_FD2_CYC)
                    : pick3(tcode, P_CD_OFF_FD0_CYC, P_CD_OFF_FD1_CYC,
                            P_CD_OFF_FD2_CYC));

    fmc_delay_timer u_cd_tmr (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .tif      (cd_if.timer)
    );

    // delayed detect state before squelch
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cd2_core_ff <= 1'b1;
        end else if (ext_timing) begin
            cd2_core_ff <= external_cd_n;
        end else if (cd_if.done) begin
            cd2_core_ff <= detector_comparator_n;
        end
    end

    // squelch hold timer, two-wire half duplex only
    assign sq_enable   = half_duplex_variant && !two_wire_select_n;
    assign sq_if.start = sq_enable && req_rise;
    assign sq_if.load  = 32'(P_SQUELCH_CYC);
    assign squelch     = sq_enable && (!transmit_request_n || sq_if.start
                                       || (sq_if.busy && !sq_if.done));

    fmc_delay_timer u_sq_tmr (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .tif      (sq_if.timer)
    );

    // receive data and delayed detect next values
    always_comb begin
        nxt_cd2 = cd2_core_ff || squelch;
        if (nxt_cd2) begin
            nxt_rd = 1'b1;
        end else if (detector_comparator_n) begin
            nxt_rd = P_RD_STOP_LEVEL;
        end else begin
            nxt_rd = demod_bit;
        end
    end

    // registered receive outputs
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cd2_ff <= 1'b1;
            rd_ff  <= 1'b1;
        end else begin
            cd2_ff <= nxt_cd2;
            rd_ff  <= nxt_rd;
        end
    end

    // soft turn-off timer started by request rise
    assign soft_if.start = req_rise;
    assign soft_if.load  = 32'(P_SOFT_CYC);
    assign tx_active     = !transmit_request_n || soft_if.start
                           || (soft_if.busy && !soft_if.done);

    fmc_delay_timer u_soft_tmr (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .tif      (soft_if.timer)
    );

    // transmit bits wait in the fifo until the next bit slot
    fmc_fifo #(
        .W     (fmc_pkg::FIFO_W),
        .DEPTH (fmc_pkg::FIFO_DEPTH)
    ) u_tx_fifo (
        .core_clk  (core_clk),
        .arst_n    (arst_n),
        .in_valid  (transmit_valid),
        .in_ready  (transmit_ready),
        .in_data   (transmit_bit_in),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_bit)
    );

    // bit slot counter, runs only while transmitting
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            bit_cnt_ff <= 32'h0;
        end else if (!tx_active || bit_tick) begin
            bit_cnt_ff <= 32'h0;
        end else begin
            bit_cnt_ff <= bit_cnt_ff + 32'h1;
        end
    end

    assign bit_tick = (bit_cnt_ff == 32'(P_BIT_CYC - 1));
    assign fifo_pop = bit_tick && fifo_valid && tx_active;

    // frequency select follows the transmit bit; idles at mark
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            mod_bit_ff <= 1'b1;
        end else if (!tx_active) begin
            mod_bit_ff <= 1'b1;
        end else if (fifo_pop) begin
            mod_bit_ff <= fifo_bit;
        end
    end

    // amplitude full while requested, stepping down during soft turn-off
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            amp_ff      <= fmc_pkg::AMP_ZERO;
            step_cnt_ff <= 32'h0;
        end else if (!transmit_request_n) begin
            amp_ff      <= fmc_pkg::AMP_FULL;
            step_cnt_ff <= 32'h0;
        end else if (!tx_active) begin
            amp_ff      <= fmc_pkg::AMP_ZERO;
            step_cnt_ff <= 32'h0;
        end else if (step_cnt_ff == 32'(SOFT_STEP_CYC - 1)) begin
            step_cnt_ff <= 32'h0;
            if (amp_ff != fmc_pkg::AMP_ZERO) begin
                amp_ff <= amp_ff - 4'h1;
            end
        end else begin
            step_cnt_ff <= step_cnt_ff + 32'h1;
        end
    end

    // transmitter enable and pin role outputs
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            tx_enable_ff   <= 1'b0;
            answer_mode_ff <= 1'b0;
            tone_on_ff     <= 1'b0;
        end else begin
            tx_enable_ff   <= tx_active;
            answer_mode_ff <= !half_duplex_variant && mode_select_pin;
            tone_on_ff     <= answer_tone_enable;
        end
    end

    assign modulated_out            = mod_bit_ff;
    assign tx_amplitude             = amp_ff;
    assign tx_enable                = tx_enable_ff;
    assign answer_mode              = answer_mode_ff;
    assign answer_tone_on           = tone_on_ff;
    assign delayed_carrier_detect_n = cd2_ff;
    assign receive_data             = rd_ff;
    assign clear_to_send_n          = cts_n_ff;

    a_tx_on_request: assert property (@(posedge core_clk) disable iff (!arst_n)
        !transmit_request_n |=> tx_enable_ff && amp_ff == fmc_pkg::AMP_FULL)
        else $error("transmitter not on during request");

    a_soft_turnoff_hold: assert property (@(posedge core_clk) disable iff (!arst_n)
        req_rise |=> tx_enable_ff [*2])
        else $error("carrier cut abruptly at request rise");

    a_raw_detect_pass: assert property (@(posedge core_clk) disable iff (!arst_n)
        raw_carrier_detect_n == detector_comparator_n
        && demod_enable == !raw_carrier_detect_n)
        else $error("raw detect or demod enable mismatch");

    a_cd2_on_delay: assert property (@(posedge core_clk) disable iff (!arst_n)
        $fell(cd2_core_ff) && !$past(ext_timing) |-> $past(cd_if.done)
        && !$past(detector_comparator_n))
        else $error("delayed detect fell without timer expiry");

    a_mark_hold: assert property (@(posedge core_clk) disable iff (!arst_n)
        delayed_carrier_detect_n |-> receive_data)
        else $error("receive data not held at mark");

    a_stop_level: assert property (@(posedge core_clk) disable iff (!arst_n)
        detector_comparator_n && !nxt_cd2 |=> receive_data == P_RD_STOP_LEVEL)
        else $error("receive data not at stop level");

    a_hd_tx_squelch: assert property (@(posedge core_clk) disable iff (!arst_n)
        sq_enable && !transmit_request_n |=> delayed_carrier_detect_n && receive_data)
        else $error("squelch not held during half duplex transmit");

    a_squelch_after: assert property (@(posedge core_clk) disable iff (!arst_n)
        sq_enable && req_rise |=> (delayed_carrier_detect_n && receive_data) [*3])
        else $error("squelch released too early");

    a_cts_off_fast: assert property (@(posedge core_clk) disable iff (!arst_n)
        transmit_request_n |=> clear_to_send_n)
        else $error("clear to send not dropped");

    a_cts_on_delay: assert property (@(posedge core_clk) disable iff (!arst_n)
        $fell(clear_to_send_n) && !$past(ext_timing) |-> $past(cts_if.done))
        else $error("clear to send without timer expiry");
endmodule
`default_nettype wire

// ### testbench/fmc_term_model.sv
`default_nettype none
module fmc_term_model (
    // clock and fifo handshake
    input  wire logic   core_clk,
    input  wire logic   send,
    input  wire logic   ready,
    output logic        valid,
    output logic        bit_out,
    output int          sent,
    // bits in the order they were taken
    output logic [31:0] hist
);
    timeunit 1ns;
    timeprecision 1ps;
    logic acc = 1'h0;
    // push seen taken at the rising edge
    always @(posedge core_clk) acc = valid && ready;
    // bit held until taken, then a new random bit
    initial begin
        valid = 1'h0;
        bit_out = 1'h1;
        sent = 0;
        hist = 32'h0;
        forever @(negedge core_clk) begin
            if (acc) begin
                hist[sent[4:0]] = bit_out;
                sent++;
                bit_out = 1'($urandom);
            end
            if (acc || !valid) valid = send;
        end
    end
endmodule
`default_nettype wire

// ### testbench/testbench.sv
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int CF [3] = '{60, 30, 45};
    localparam int SQ = 70;
    localparam int SOFT = 32;
    localparam int CTS_HD = 50, BITC = 20, CDON_HD = 50, CDOFF_HD = 40;
    localparam int CDON [3] = '{40, 20, 35};
    localparam int CDOFF [3] = '{25, 26, 22};
    localparam logic STOPL = 1'h1;
    logic core_clk = 1'h0, arst_n = 1'h0, req_n = 1'h1, hd = 1'h0, msel = 1'h1;
    logic ts_lo = 1'h0, ts_hi = 1'h0, cmp_n = 1'h1, dbit = 1'h0;
    logic ecs_n = 1'h1, ecd_n = 1'h1, send = 1'h0;
    logic vld, tbit, rdy, mo, txe, am, ato, raw_n, dcd_n, rd, cts_n, den;
    logic [3:0] amp;
    logic [31:0] hist;
    int sent, n, n_errors = 0, checks = 0;
    always #5 core_clk = ~core_clk;
    task automatic chk(input string what, input logic exp, input logic got);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s exp %b got %b", what, exp, got);
        end
    endtask
    task automatic chk_rng(input string what, input int lo, input int hi, input int got);
        checks++;
        if (got < lo || got > hi) begin
            n_errors++;
            $display("BAD %s exp %0d..%0d got %0d", what, lo, hi, got);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge core_clk);
    endtask
    task automatic print_verdict;
        if (n_errors == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // bounded wait for clear to send
    task automatic wait_cts(output int k);
        k = 0;
        while (cts_n !== 1'h0 && k < 1000) begin
            cyc(1);
            k++;
        end
        if (k == 1000) begin
            n_errors++;
            print_verdict;
        end
    endtask
    fmc_term_model fmc_term_model_i (.core_clk(core_clk), .send(send), .ready(rdy),
        .valid(vld), .bit_out(tbit), .sent(sent), .hist(hist));
    fmc_modem_ctrl #(.P_CTS_FD0_CYC(CF[0]), .P_CTS_FD1_CYC(CF[1]), .P_CTS_FD2_CYC(CF[2]),
        .P_CTS_HD_CYC(CTS_HD), .P_CD_ON_FD0_CYC(CDON[0]), .P_CD_ON_FD1_CYC(CDON[1]),
        .P_CD_ON_FD2_CYC(CDON[2]), .P_CD_OFF_FD0_CYC(CDOFF[0]), .P_CD_OFF_FD1_CYC(CDOFF[1]),
        .P_CD_OFF_FD2_CYC(CDOFF[2]), .P_CD_ON_HD_CYC(CDON_HD), .P_CD_OFF_HD_CYC(CDOFF_HD),
        .P_SQUELCH_CYC(SQ), .P_SOFT_CYC(SOFT), .P_BIT_CYC(BITC), .P_RD_STOP_LEVEL(STOPL))
    fmc_modem_ctrl_i (.core_clk(core_clk), .arst_n(arst_n), .transmit_request_n(req_n),
        .transmit_bit_in(tbit), .transmit_valid(vld), .transmit_ready(rdy),
        .half_duplex_variant(hd), .mode_select_pin(msel), .timer_select_lo(ts_lo),
        .timer_select_hi(ts_hi), .detector_comparator_n(cmp_n), .demod_bit(dbit),
        .external_cts_n(ecs_n), .external_cd_n(ecd_n), .modulated_out(mo),
        .tx_amplitude(amp), .tx_enable(txe), .answer_mode(am), .answer_tone_on(ato),
        .raw_carrier_detect_n(raw_n), .delayed_carrier_detect_n(dcd_n), .receive_data(rd),
        .clear_to_send_n(cts_n), .demod_enable(den));
    initial begin
        void'($urandom(91));
        cyc(2);
        chk("rst_cts", 1'h1, cts_n);
        chk("rst_txe", 1'h0, txe);
        arst_n = 1'h1;
        cyc(3);
        chk("answer", 1'h1, am);
        // delay per timer code, then soft turn-off
        for (int c = 0; c < 3; c++) begin
            {ts_hi, ts_lo} = 2'(c);
            cyc(2);
            req_n = 1'h0;
            wait_cts(n);
            chk_rng("cts_on", CF[c] + 1, CF[c] + 3, n);
            chk("txe_on", 1'h1, txe);
            chk("amp_full", 1'h1, amp == 4'hf);
            req_n = 1'h1;
            cyc(1);
            chk("cts_off", 1'h1, cts_n);
            cyc(SOFT / 2);
            chk("soft_on", 1'h1, txe);
            chk("soft_ramp", 1'h1, amp > 4'h0 && amp < 4'hf);
            cyc(SOFT);
            chk("soft_end", 1'h0, txe);
            chk("amp_off", 1'h1, amp == 4'h0);
        end
        // new fall restarts the timer
        {ts_hi, ts_lo} = 2'h0;
        req_n = 1'h0;
        cyc(30);
        req_n = 1'h1;
        cyc(1);
        req_n = 1'h0;
        wait_cts(n);
        chk_rng("restart", CF[0] + 1, CF[0] + 3, n);
        req_n = 1'h1;
        {ts_hi, ts_lo, ecs_n, ecd_n} = 4'hc;
        cyc(1);
        req_n = 1'h0;
        cyc(3);
        chk("ext_cts", 1'h0, cts_n);
        chk("ext_cd", 1'h0, dcd_n);
        {ecs_n, ecd_n} = 2'h3;
        cyc(2);
        {ts_hi, ts_lo} = 2'h0;
        req_n = 1'h1;
        cyc(3);
        // carrier on and off through the detect delays
        cmp_n = 1'h0;
        #1;
        chk("raw_on", 1'h0, raw_n);
        chk("demod_on", 1'h1, den);
        cyc(2);
        chk("mark_hold", 1'h1, rd);
        cyc(CDON[0] - 4);
        chk("cd_early", 1'h1, dcd_n);
        cyc(8);
        chk("cd_on", 1'h0, dcd_n);
        repeat (10) begin
            dbit = 1'($urandom);
            cyc(2);
            chk("rx_data", dbit, rd);
        end
        dbit = 1'h0;
        cmp_n = 1'h1;
        #1;
        chk("demod_off", 1'h0, den);
        cyc(2);
        chk("stop_lvl", STOPL, rd);
        cyc(CDOFF[0] - 4);
        chk("cd_late", 1'h0, dcd_n);
        cyc(8);
        chk("cd_off", 1'h1, dcd_n);
        // two-wire squelch
        {hd, msel, ts_hi} = 3'h5;
        req_n = 1'h0;
        cmp_n = 1'h0;
        cyc(60);
        chk("sq_cd", 1'h1, dcd_n);
        chk("sq_rd", 1'h1, rd);
        chk("tone", 1'h1, ato);
        chk("answer_off", 1'h0, am);
        req_n = 1'h1;
        cyc(SQ / 2);
        chk("sq_hold", 1'h1, dcd_n);
        cyc(SQ + 60);
        chk("sq_end", 1'h0, dcd_n);
        // fill fifo while idle, then drain while sending
        {hd, msel, cmp_n, ts_hi} = 4'h6;
        send = 1'h1;
        n = 0;
        while (rdy !== 1'h0 && n < 40) begin
            cyc(1);
            n++;
        end
        if (n == 40) begin
            n_errors++;
            print_verdict;
        end
        send = 1'h0;
        cyc(3);
        chk_rng("fifo_fill", 8, 8, sent);
        req_n = 1'h0;
        for (int i = 0; i < 8; i++) begin
            cyc(i == 0 ? BITC + 1 : BITC);
            chk("tx_bit", hist[i], mo);
        end
        chk("drained", 1'h1, rdy);
        req_n = 1'h1;
        print_verdict;
    end
endmodule
`default_nettype wire
